// File: design/ucr_cfg.svh
/*
  Named constants for the control endpoint request handler: packet ids,
  request codes, descriptor images and defaults.
  Assumes it is included by bare name after the package.
*/
`ifndef UCR_CFG_SVH
`define UCR_CFG_SVH
// ----------------------------------------
// token packet ids (4-bit pid field)
// ----------------------------------------
`define UCR_PID_OUT 4'h1
`define UCR_PID_IN 4'h9
`define UCR_PID_SETUP 4'hd
`define UCR_EP0 4'h0
// ----------------------------------------
// standard request codes
// ----------------------------------------
`define UCR_RQ_GET_STATUS 8'h00
`define UCR_RQ_CLR_FEATURE 8'h01
`define UCR_RQ_SET_FEATURE 8'h03
`define UCR_RQ_SET_ADDRESS 8'h05
`define UCR_RQ_GET_DESC 8'h06
`define UCR_RQ_SET_DESC 8'h07
`define UCR_RQ_GET_CONFIG 8'h08
`define UCR_RQ_SET_CONFIG 8'h09
`define UCR_RQ_GET_IFACE 8'h0a
`define UCR_RQ_SET_IFACE 8'h0b
`define UCR_RQ_SYNCH_FRAME 8'h0c
// ----------------------------------------
// setup field decoding
// ----------------------------------------
`define UCR_TYPE_STD 2'h0
`define UCR_RCP_ENDPOINT 5'h02
`define UCR_FEAT_HALT 16'h0000
`define UCR_SETUP_LAST 4'h7
`define UCR_DT_DEVICE 8'h01
`define UCR_DT_CONFIG 8'h02
`define UCR_DT_STRING 8'h03
`define UCR_ADDR_DEFAULT 7'h00
`define UCR_EP0_MAXP 7'h40
// ----------------------------------------
// descriptor images, first byte leftmost
// ----------------------------------------
`define UCR_LEN_DEV 16'h0012
`define UCR_LEN_CFG 16'h0019
`define UCR_LEN_STR0 16'h0004
`define UCR_LEN_STR1 16'h0006
// vendor 0x1234 and product 0x5678 are arbitrary values
`define UCR_DESC_DEV 144'h12_01_10_01_00_00_00_40_34_12_78_56_00_01_00_01_00_01
`define UCR_DESC_CFG 200'h09_02_19_00_01_01_00_80_32_09_04_00_00_01_ff_00_00_00_07_05_81_03_40_00_0a
`define UCR_DESC_STR0 32'h04_03_09_04
`define UCR_DESC_STR1 48'h06_03_75_00_63_00
`endif

// File: design/ucr_pkg.sv
/*
  Types shared by the control endpoint request handler.
  Assumes nothing of its surroundings.
*/
package ucr_pkg;
  // control transfer stage, one-hot
  typedef enum logic [5:0] {
    UCR_ST_IDLE = 6'b000001,
    UCR_ST_SETUP = 6'b000010,
    UCR_ST_DIN = 6'b000100,
    UCR_ST_DOUT = 6'b001000,
    UCR_ST_STIN = 6'b010000,
    UCR_ST_STOUT = 6'b100000
  } ucr_state_t;
  // answer placed on the link by the device
  typedef enum logic [1:0] {
    UCR_HS_ACK = 2'h0,
    UCR_HS_NAK = 2'h1,
    UCR_HS_STALL = 2'h2,
    UCR_HS_ZLP = 2'h3
  } ucr_hs_t;
  // source of the in-direction data stage
  typedef enum logic [2:0] {
    UCR_RS_DEV = 3'h0,
    UCR_RS_CFG = 3'h1,
    UCR_RS_STR0 = 3'h2,
    UCR_RS_STR1 = 3'h3,
    UCR_RS_VAL = 3'h4
  } ucr_rsel_t;
endpackage : ucr_pkg

// File: design/ucr_ram.sv
/*
  Endpoint packet buffer: one write port, one read port, registered read.
  Assumes a single clock and that the writer keeps addresses in range.
*/
`timescale 1ns/1ps
`default_nettype none
module ucr_ram #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // clock
  input wire logic ref_clk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // storage, no reset so it maps onto block memory
  logic [7:0] mem [DEPTH];

  // write port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, one cycle of latency
  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : ucr_ram
`default_nettype wire

// File: design/ucr_ctrl_ep.sv
/*
  Device-side control endpoint request handler: takes decoded tokens and
  data bytes from the serial engine, parses setup packets, answers standard
  requests and feeds in-direction bytes through a two-entry buffer.
  Assumes a packet engine on ref_clk that decodes tokens, checks crc and
  serialises the answers at full speed.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ucr_cfg.svh"
module ucr_ctrl_ep #(
  parameter int NUM_EP = 16,
  parameter int BUF_AW = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // token from the packet engine
  input wire logic tok_valid,
  input wire logic [3:0] tok_pid,
  input wire logic [6:0] tok_addr,
  input wire logic [3:0] tok_endp,
  // received data packet bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  // handshake answer
  output logic hs_valid,
  output ucr_pkg::ucr_hs_t hs_code,
  // in-direction data bytes
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  input wire logic tx_ready,
  // device state seen by the application
  output logic [6:0] dev_addr,
  output logic [7:0] cfg_value,
  output logic [7:0] alt_setting,
  output logic [NUM_EP-1:0] ep_halt,
  output logic full_speed,
  // request notice and out-stage buffer
  output logic req_valid,
  output logic [7:0] req_type,
  output logic [7:0] req_code,
  output logic [15:0] req_value,
  output logic [15:0] req_index,
  output logic [15:0] req_length,
  input wire logic [BUF_AW-1:0] buf_rd_addr,
  output logic [7:0] buf_rd_data
);
  import ucr_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction : min16

  // byte idx of an image whose first byte sits at the top
  function automatic logic [7:0] pick(input logic [199:0] img, input logic [15:0] n, input logic [15:0] idx);
    logic [199:0] t;
    t = img >> {n - idx - 16'h0001, 3'h0};
    return t[7:0];
  endfunction : pick

  // ----------------------------------------
  // state
  // ----------------------------------------
  ucr_state_t st; // control stage
  logic [3:0] su_cnt; // setup byte count
  logic dec_go; // setup complete, decode next cycle
  logic stall_req; // current request refused
  logic addr_pend; // set address waits for status
  logic [6:0] new_addr; // address to take
  ucr_rsel_t rsel; // in-data source
  logic [7:0] rep_val; // one-byte answers
  logic [15:0] rep_len; // bytes to return
  logic [15:0] in_idx; // next byte to send
  logic [6:0] pkt_left; // bytes left in this packet
  logic pkt_busy; // packet being produced
  logic [BUF_AW-1:0] wr_ptr; // out-stage write index
  logic [1:0] b_cnt; // buffer fill
  logic [7:0] b1_byte; // second buffer entry
  logic b1_last;

  wire logic tok_hit = tok_valid && (tok_addr == dev_addr);
  wire logic tok_ep0 = tok_hit && (tok_endp == `UCR_EP0);
  wire logic tok_in = tok_ep0 && (tok_pid == `UCR_PID_IN);
  wire logic tok_out = tok_ep0 && (tok_pid == `UCR_PID_OUT);
  wire logic tok_setup = tok_ep0 && (tok_pid == `UCR_PID_SETUP);
  wire logic tok_epn = tok_hit && (tok_endp != `UCR_EP0) && (tok_pid != `UCR_PID_SETUP);
  wire logic push = pkt_busy && (b_cnt != 2'h2); // full buffer stalls producer
  wire logic pop = tx_valid && tx_ready;
  wire logic push_last = (pkt_left == 7'h01);
  logic [7:0] push_byte;
  // size of the next in packet, never above one ep0 packet
  logic [15:0] pkt_span;
  assign pkt_span = min16(rep_len - in_idx, {9'h000, `UCR_EP0_MAXP});

  // only full speed is built; low speed never signalled
  assign full_speed = 1'b1;

  // ----------------------------------------
  // in-data source
  // ----------------------------------------
  // descriptors are constant images; one-byte answers come from rep_val
  always_comb begin
    unique case (rsel)
      UCR_RS_DEV: push_byte = pick({56'h0, `UCR_DESC_DEV}, `UCR_LEN_DEV, in_idx);
      UCR_RS_CFG: push_byte = pick(`UCR_DESC_CFG, `UCR_LEN_CFG, in_idx);
      UCR_RS_STR0: push_byte = pick({168'h0, `UCR_DESC_STR0}, `UCR_LEN_STR0, in_idx);
      UCR_RS_STR1: push_byte = pick({152'h0, `UCR_DESC_STR1}, `UCR_LEN_STR1, in_idx);
      default: push_byte = (in_idx == 16'h0000) ? rep_val : 8'h00;
    endcase
  end

  // ----------------------------------------
  // setup parsing
  // ----------------------------------------
  // fields fill in arrival order, two-byte ones low byte first
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      su_cnt <= 4'h0;
      dec_go <= 1'b0;
      {req_type, req_code, req_value, req_index, req_length} <= 64'h0;
    end else begin
      dec_go <= 1'b0;
      if (tok_setup) begin
        su_cnt <= 4'h0;
      end else if ((st == UCR_ST_SETUP) && rx_valid) begin
        su_cnt <= su_cnt + 4'h1;
        unique case (su_cnt)
          4'h0: req_type <= rx_byte;
          4'h1: req_code <= rx_byte;
          4'h2: req_value[7:0] <= rx_byte;
          4'h3: req_value[15:8] <= rx_byte;
          4'h4: req_index[7:0] <= rx_byte;
          4'h5: req_index[15:8] <= rx_byte;
          4'h6: req_length[7:0] <= rx_byte;
          4'h7: req_length[15:8] <= rx_byte;
          default: ;
        endcase
        dec_go <= rx_last && (su_cnt == `UCR_SETUP_LAST); // short packets are dropped
      end
    end
  end
  assign req_valid = dec_go; // class and vendor codes reach the application

  // ----------------------------------------
  // request decode and device state
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stall_req <= 1'b0;
      addr_pend <= 1'b0;
      new_addr <= `UCR_ADDR_DEFAULT;
      dev_addr <= `UCR_ADDR_DEFAULT;
      cfg_value <= 8'h00;
      alt_setting <= 8'h00;
      ep_halt <= '0;
      rsel <= UCR_RS_VAL;
      rep_val <= 8'h00;
      rep_len <= 16'h0000;
    end else if (dec_go) begin
      stall_req <= 1'b0;
      addr_pend <= 1'b0;
      rsel <= UCR_RS_VAL;
      rep_val <= 8'h00;
      rep_len <= 16'h0000;
      if (req_type[6:5] != `UCR_TYPE_STD) begin
        stall_req <= 1'b1;
      end else begin
        unique case (req_code)
          `UCR_RQ_GET_STATUS: begin
            rep_len <= min16(req_length, 16'h0002);
            if (req_type[4:0] == `UCR_RCP_ENDPOINT) begin
              rep_val <= {7'h00, ep_halt[req_index[3:0]]};
            end
          end
          `UCR_RQ_CLR_FEATURE, `UCR_RQ_SET_FEATURE: begin
            if ((req_type[4:0] == `UCR_RCP_ENDPOINT) && (req_value == `UCR_FEAT_HALT)
                && (req_index[3:0] != `UCR_EP0)) begin
              ep_halt[req_index[3:0]] <= (req_code == `UCR_RQ_SET_FEATURE);
            end else begin
              stall_req <= 1'b1;
            end
          end
          `UCR_RQ_SET_ADDRESS: begin
            addr_pend <= 1'b1;
            new_addr <= req_value[6:0];
          end
          `UCR_RQ_GET_DESC: begin
            unique case (req_value[15:8])
              `UCR_DT_DEVICE: begin
                rsel <= UCR_RS_DEV;
                rep_len <= min16(req_length, `UCR_LEN_DEV);
              end
              `UCR_DT_CONFIG: begin
                rsel <= UCR_RS_CFG;
                rep_len <= min16(req_length, `UCR_LEN_CFG);
              end
              `UCR_DT_STRING: begin
                rsel <= (req_value[7:0] == 8'h00) ? UCR_RS_STR0 : UCR_RS_STR1;
                rep_len <= min16(req_length, (req_value[7:0] == 8'h00) ? `UCR_LEN_STR0 : `UCR_LEN_STR1);
                stall_req <= (req_value[7:0] > 8'h01);
              end
              default: stall_req <= 1'b1; // missing descriptor
            endcase
          end
          `UCR_RQ_SET_DESC: ; // data lands in the buffer for the application
          `UCR_RQ_GET_CONFIG: begin
            rep_val <= cfg_value;
            rep_len <= min16(req_length, 16'h0001);
          end
          `UCR_RQ_SET_CONFIG: begin
            cfg_value <= req_value[7:0];
            alt_setting <= 8'h00; // new configuration starts at setting zero
          end
          `UCR_RQ_GET_IFACE: begin
            rep_val <= alt_setting;
            rep_len <= min16(req_length, 16'h0001);
          end
          `UCR_RQ_SET_IFACE: alt_setting <= req_value[7:0]; // one register, one setting
          `UCR_RQ_SYNCH_FRAME: rep_len <= min16(req_length, 16'h0002);
          default: stall_req <= 1'b1;
        endcase
      end
    end else if ((st == UCR_ST_STIN) && tok_in && addr_pend && !stall_req) begin
      dev_addr <= new_addr; // only after the status stage
      addr_pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // control stage sequencing and answers
  // ----------------------------------------
  // every answer follows a token or packet from the host
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= UCR_ST_IDLE;
      hs_valid <= 1'b0;
      hs_code <= UCR_HS_ACK;
      in_idx <= 16'h0000;
      pkt_left <= 7'h00;
      pkt_busy <= 1'b0;
      wr_ptr <= '0;
    end else begin
      hs_valid <= 1'b0;
      if (push) begin
        in_idx <= in_idx + 16'h0001;
        pkt_left <= pkt_left - 7'h01;
        pkt_busy <= !push_last;
      end
      if (tok_setup) begin
        st <= UCR_ST_SETUP; // setup always restarts the pipe
        pkt_busy <= 1'b0;
      end else if (tok_epn) begin
        hs_valid <= 1'b1; // no data path on other numbers
        hs_code <= ep_halt[tok_endp] ? UCR_HS_STALL : UCR_HS_NAK;
      end else begin
        unique case (st)
          UCR_ST_IDLE: begin
            if (tok_in || tok_out) begin
              hs_valid <= 1'b1;
              hs_code <= UCR_HS_NAK;
            end
          end
          UCR_ST_SETUP: begin
            if (rx_valid && rx_last) begin
              hs_valid <= (su_cnt == `UCR_SETUP_LAST);
              hs_code <= UCR_HS_ACK;
              if (su_cnt != `UCR_SETUP_LAST) begin
                st <= UCR_ST_IDLE;
              end
            end
            if (dec_go) begin
              in_idx <= 16'h0000;
              wr_ptr <= '0;
              if (req_length == 16'h0000) begin
                st <= UCR_ST_STIN;
              end else begin
                st <= req_type[7] ? UCR_ST_DIN : UCR_ST_DOUT;
              end
            end
          end
          UCR_ST_DIN: begin
            if (tok_in) begin
              if (stall_req) begin
                hs_valid <= 1'b1;
                hs_code <= UCR_HS_STALL;
              end else if (pkt_busy || (b_cnt != 2'h0)) begin
                hs_valid <= 1'b1;
                hs_code <= UCR_HS_NAK;
              end else if (in_idx >= rep_len) begin
                hs_valid <= 1'b1;
                hs_code <= UCR_HS_ZLP;
              end else begin
                pkt_busy <= 1'b1; // at most one packet of ep0 size
                pkt_left <= pkt_span[6:0];
              end
            end else if (tok_out) begin
              st <= UCR_ST_STOUT;
            end
          end
          UCR_ST_DOUT: begin
            if (tok_in) begin
              hs_valid <= 1'b1;
              hs_code <= stall_req ? UCR_HS_STALL : UCR_HS_ZLP;
              st <= UCR_ST_IDLE;
            end else if (rx_valid && rx_last) begin
              hs_valid <= 1'b1;
              hs_code <= stall_req ? UCR_HS_STALL : UCR_HS_ACK;
            end
            if (rx_valid && !stall_req) begin
              wr_ptr <= wr_ptr + 1'b1;
            end
          end
          UCR_ST_STIN: begin
            if (tok_in) begin
              hs_valid <= 1'b1;
              hs_code <= stall_req ? UCR_HS_STALL : UCR_HS_ZLP;
              st <= UCR_ST_IDLE;
            end
          end
          UCR_ST_STOUT: begin
            if (rx_valid && rx_last) begin
              hs_valid <= 1'b1;
              hs_code <= stall_req ? UCR_HS_STALL : UCR_HS_ACK;
              st <= UCR_ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // two-entry output buffer
  // ----------------------------------------
  // a stall by the engine holds both entries; the producer waits on b_cnt
  assign tx_valid = (b_cnt != 2'h0);
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      b_cnt <= 2'h0;
      tx_byte <= 8'h00;
      tx_last <= 1'b0;
      b1_byte <= 8'h00;
      b1_last <= 1'b0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          if (b_cnt == 2'h0) begin
            {tx_byte, tx_last} <= {push_byte, push_last};
          end else begin
            {b1_byte, b1_last} <= {push_byte, push_last};
          end
          b_cnt <= b_cnt + 2'h1;
        end
        2'b01: begin
          {tx_byte, tx_last} <= {b1_byte, b1_last};
          b_cnt <= b_cnt - 2'h1;
        end
        2'b11: begin
          if (b_cnt == 2'h1) begin
            {tx_byte, tx_last} <= {push_byte, push_last};
          end else begin
            {tx_byte, tx_last} <= {b1_byte, b1_last};
            {b1_byte, b1_last} <= {push_byte, push_last};
          end
        end
        default: ;
      endcase
    end
  end

  // out-stage packet store, one full ep0 packet deep
  ucr_ram #(.DEPTH(1 << BUF_AW), .AW(BUF_AW)) u_buf (
    .ref_clk(ref_clk),
    .wr_en((st == UCR_ST_DOUT) && rx_valid && !stall_req),
    .wr_addr(wr_ptr),
    .wr_data(rx_byte),
    .rd_addr(buf_rd_addr),
    .rd_data(buf_rd_data)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_foreign;
    @(posedge ref_clk) disable iff (!rst_b)
    tok_valid && (tok_addr != dev_addr) && (st == UCR_ST_IDLE) && !rx_valid |=> !hs_valid;
  endproperty
  a_foreign: assert property (p_foreign) else $error("answer to another address");
  property p_nak_idle;
    @(posedge ref_clk) disable iff (!rst_b)
    tok_in && (st == UCR_ST_IDLE) |=> hs_valid && (hs_code == UCR_HS_NAK);
  endproperty
  a_nak_idle: assert property (p_nak_idle) else $error("idle in token not naked");
  property p_unsup;
    @(posedge ref_clk) disable iff (!rst_b)
    dec_go && (req_type[6:5] == `UCR_TYPE_STD) && (req_code > `UCR_RQ_SYNCH_FRAME) |=> stall_req;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unknown request not stalled");
  property p_pkt_max;
    @(posedge ref_clk) disable iff (!rst_b)
    pkt_left <= `UCR_EP0_MAXP;
  endproperty
  a_pkt_max: assert property (p_pkt_max) else $error("packet above ep0 size");
  property p_alt;
    @(posedge ref_clk) disable iff (!rst_b)
    dec_go && (req_type[6:5] == `UCR_TYPE_STD) && (req_code == `UCR_RQ_SET_IFACE)
      |=> alt_setting == $past(req_value[7:0]);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate setting not taken");
  property p_len_order;
    @(posedge ref_clk) disable iff (!rst_b)
    dec_go |-> (req_length[15:8] == $past(rx_byte)) && (req_length[7:0] == $past(rx_byte, 2));
  endproperty
  a_len_order: assert property (p_len_order) else $error("length bytes swapped");
  property p_no_data;
    @(posedge ref_clk) disable iff (!rst_b)
    dec_go && (req_length == 16'h0000) && !tok_setup |=> st == UCR_ST_STIN;
  endproperty
  a_no_data: assert property (p_no_data) else $error("data stage not skipped");
  property p_addr;
    @(posedge ref_clk) disable iff (!rst_b)
    (st == UCR_ST_STIN) && tok_in && addr_pend && !stall_req && !tok_setup
      |=> (dev_addr == $past(new_addr)) ##1 (dev_addr == $past(new_addr, 2));
  endproperty
  a_addr: assert property (p_addr) else $error("new address not kept");
endmodule : ucr_ctrl_ep
`default_nettype wire

// File: dv/ucr_host.sv
/* host-side model: drives tokens and data packets, drains in-direction bytes.
   assumes the handler samples everything on rising ref_clk edges. */
`timescale 1ns/1ps
`default_nettype none
module ucr_host (
  // clock
  input wire logic ref_clk,
  // toward the device
  output logic tok_valid,
  output logic [3:0] tok_pid,
  output logic [6:0] tok_addr,
  output logic [3:0] tok_endp,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_last,
  // from the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready
);
  initial begin
    {tok_valid, tok_pid, tok_addr, tok_endp, rx_valid, rx_byte, rx_last, tx_ready} = '0;
  end
  // one-cycle token; released lines show the inverse so stale values never match
  task automatic token(input logic [3:0] pid, input logic [6:0] a, input logic [3:0] ep);
    @(negedge ref_clk);
    tok_valid = 1'b1;
    {tok_pid, tok_addr, tok_endp} = {pid, a, ep};
    @(negedge ref_clk);
    tok_valid = 1'b0;
    {tok_pid, tok_addr, tok_endp} = ~{pid, a, ep};
  endtask : token
  // n bytes back to back, lowest byte of d first
  task automatic data(input logic [63:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      {rx_valid, rx_byte, rx_last} = {1'b1, d[8*i+:8], i == n - 1};
      @(negedge ref_clk);
    end
    {rx_valid, rx_byte, rx_last} = {1'b0, ~rx_byte, 1'b0};
  endtask : data
  // drain n bytes, stalling one cycle in three so the buffer fills
  task automatic take(input int n, output logic [199:0] got, output logic last_ok);
    int k;
    k = 0;
    got = '0;
    last_ok = 1'b0;
    for (int c = 0; c < 300 && k < n; c++) begin
      @(negedge ref_clk);
      tx_ready = tx_valid && (c % 3 != 2);
      if (tx_ready) begin
        got = {got[191:0], tx_byte};
        last_ok = tx_last;
        k++;
      end
    end
    @(negedge ref_clk);
    tx_ready = 1'b0;
  endtask : take
endmodule : ucr_host
`default_nettype wire

// File: dv/usb_control_endpoint_request_handler_tb_top.sv
/* self-checking bench for the control endpoint handler, one task per scenario.
   assumes the package, config header, design and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "ucr_cfg.svh"
module usb_control_endpoint_request_handler_tb_top;
  import ucr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic tok_valid, rx_valid, rx_last, hs_valid, tx_valid, tx_last, tx_ready, full_speed, req_valid;
  logic [3:0] tok_pid, tok_endp;
  logic [6:0] tok_addr, dev_addr;
  logic [7:0] rx_byte, tx_byte, cfg_value, alt_setting, req_type, req_code, buf_rd_data;
  logic [15:0] ep_halt, req_value, req_index, req_length;
  logic [5:0] buf_rd_addr = 6'h00;
  ucr_hs_t hs_code;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [6:0] dev = 7'h00; // address the host currently uses
  always #2 ref_clk = ~ref_clk;
  ucr_ctrl_ep DUT (.ref_clk, .rst_b, .tok_valid, .tok_pid, .tok_addr, .tok_endp, .rx_valid,
    .rx_byte, .rx_last, .hs_valid, .hs_code, .tx_valid, .tx_byte, .tx_last, .tx_ready, .dev_addr,
    .cfg_value, .alt_setting, .ep_halt, .full_speed, .req_valid, .req_type, .req_code,
    .req_value, .req_index, .req_length, .buf_rd_addr, .buf_rd_data);
  ucr_host host (.ref_clk, .tok_valid, .tok_pid, .tok_addr, .tok_endp, .rx_valid, .rx_byte,
    .rx_last, .tx_valid, .tx_byte, .tx_last, .tx_ready);
  task automatic summarize;
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input string w, input logic [199:0] e, input logic [199:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  // {seen, code}; a silent device gives 3'h0
  task automatic want_hs(input string w, input logic [2:0] e);
    logic [2:0] g;
    g = 3'h0;
    // the strobe may already stand when the driving task returns
    for (int i = 0; i < 8 && g[2] !== 1'b1; i++) begin
      if (hs_valid === 1'b1) g = {1'b1, hs_code};
      else @(negedge ref_clk);
    end
    chk(w, e, g);
  endtask : want_hs
  // setup stage, then the two idle cycles the decoder needs
  task automatic setup(input logic [63:0] d);
    host.token(`UCR_PID_SETUP, dev, `UCR_EP0);
    host.data(d, 8);
    want_hs("setup ack", {1'b1, UCR_HS_ACK});
    chk("req_valid", 1'b1, req_valid);
    repeat (2) @(negedge ref_clk);
  endtask : setup
  task automatic s_reset;
    chk("dev_addr", 7'h00, dev_addr);
    chk("full_speed", 1'b1, full_speed);
    chk("cfg_value", 8'h00, cfg_value);
  endtask : s_reset
  task automatic s_idle;
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("idle in", {1'b1, UCR_HS_NAK});
    host.token(`UCR_PID_OUT, dev, 4'h3);
    want_hs("ep3 out", {1'b1, UCR_HS_NAK});
    host.token(`UCR_PID_IN, 7'h2a, `UCR_EP0);
    want_hs("foreign addr", 3'h0);
  endtask : s_idle
  task automatic s_get_dev;
    logic [199:0] got;
    logic lst;
    setup({16'h0012, 16'h0000, 16'h0100, `UCR_RQ_GET_DESC, 8'h80});
    chk("req_value", 16'h0100, req_value);
    chk("req_length", 16'h0012, req_length);
    chk("req_type", 8'h80, req_type);
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    host.take(18, got, lst);
    chk("device desc", `UCR_DESC_DEV, got);
    chk("ep0 size", 8'h40, got[87:80]);
    chk("last flag", 1'b1, lst);
    host.token(`UCR_PID_OUT, dev, `UCR_EP0);
    host.data(64'h0, 1);
    want_hs("in status", {1'b1, UCR_HS_ACK});
  endtask : s_get_dev
  task automatic s_set_addr;
    setup({32'h0, 16'h0005, `UCR_RQ_SET_ADDRESS, 8'h00});
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("addr status", {1'b1, UCR_HS_ZLP});
    chk("new dev_addr", 7'h05, dev_addr);
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("old addr", 3'h0);
    dev = 7'h05;
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("new addr", {1'b1, UCR_HS_NAK});
  endtask : s_set_addr
  task automatic s_cfg_stall;
    setup({32'h0, 16'h0001, `UCR_RQ_SET_CONFIG, 8'h00});
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("cfg status", {1'b1, UCR_HS_ZLP});
    chk("cfg_value", 8'h01, cfg_value);
    chk("alt_setting", 8'h00, alt_setting);
    // code 2 is not a standard request
    setup({48'h0, 8'h02, 8'h00});
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("bad request", {1'b1, UCR_HS_STALL});
    setup({48'h0, 8'h0d, 8'h00});
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("code 13", {1'b1, UCR_HS_STALL});
    setup({32'h0, 16'h0003, `UCR_RQ_SET_IFACE, 8'h01});
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("iface status", {1'b1, UCR_HS_ZLP});
    chk("alt_setting", 8'h03, alt_setting);
  endtask : s_cfg_stall
  // halt, status readback and an out data stage into the buffer
  task automatic s_more;
    logic [199:0] got;
    logic lst;
    setup({16'h0000, 16'h0002, 16'h0000, `UCR_RQ_SET_FEATURE, 8'h02});
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("halt status", {1'b1, UCR_HS_ZLP});
    chk("ep_halt", 16'h0004, ep_halt);
    host.token(`UCR_PID_OUT, dev, 4'h2);
    want_hs("halted ep2", {1'b1, UCR_HS_STALL});
    setup({16'h0002, 16'h0002, 16'h0000, `UCR_RQ_GET_STATUS, 8'h82});
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    host.take(2, got, lst);
    chk("ep2 status", 16'h0100, got);
    host.token(`UCR_PID_OUT, dev, `UCR_EP0);
    host.data(64'h0, 1);
    want_hs("status ack", {1'b1, UCR_HS_ACK});
    setup({16'h0002, 32'h0, `UCR_RQ_SET_DESC, 8'h00});
    host.token(`UCR_PID_OUT, dev, `UCR_EP0);
    host.data(64'ha55a, 2);
    want_hs("desc data", {1'b1, UCR_HS_ACK});
    host.token(`UCR_PID_IN, dev, `UCR_EP0);
    want_hs("desc status", {1'b1, UCR_HS_ZLP});
    buf_rd_addr = 6'h01;
    @(negedge ref_clk);
    chk("buf_rd_data", 8'ha5, buf_rd_data);
  endtask : s_more
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    s_reset();
    s_idle();
    s_get_dev();
    s_set_addr();
    s_cfg_stall();
    s_more();
    summarize();
  end
endmodule : usb_control_endpoint_request_handler_tb_top
`default_nettype wire
